/* verilog/dtmc_timer_ctrl.v */
// Functional notes
// - mode bit7: 0 transmit, 1 demodulate
// - bit0 sets long timer start level
// - bit1 sets carrier timer start level
// - demod bit0 falling flag, write-1 clears
// - demod bit1 rising flag, write-1 clears
// - transmit bits3:2 normal/pingpong/force0/force1
// - demod bits3:2 filter none/4/8 cycles
// - transmit bits5:4 AND/OR/NOR/NAND combine
// - demod bits5:4 edge fall/rise/both
// - transmit bit6 routes combined output to pin
// - demod bit6 selects primary/alternate input
// - logic field, sync kept over stop recovery
// - enable reserved bits read ones
// - sync enable bit, reset zero
// - carrier enable reads running state
// - long enable reads running state
// - sync aligns first carrier pulse
// - enable loads reload, sets start level
// - zero toggles output (long only with bits3:2 00 or pingpong), sets timeout
// - single-pass stops, modulo reloads
// - pingpong alternates enables, timeouts
//
// Strobed register access was decided locally.
`include "dtmc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module dtmc_timer_ctrl (
  input  wire       mclk_in,
  input  wire       rst_n_in,
  input  wire       stop_recovery_in,
  input  wire [3:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       primary_demod_pin_in,
  input  wire       alternate_demod_pin_in,
  input  wire       port_data_in,
  output wire       shared_output_pin_out,
  output reg        carrier_timer_output_out,
  output reg        long_timer_output_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]  mode_reg;
  reg        sync_reg;
  reg        car_en_reg;
  reg        long_en_reg;
  reg        car_modulo_reg;
  reg        car_tout_reg;
  reg        long_modulo_reg;
  reg        long_tout_reg;
  reg [7:0]  car_reload_reg;
  reg [7:0]  reload_hi_reg;
  reg [7:0]  reload_lo_reg;
  reg [7:0]  car_cnt_reg;
  reg [15:0] long_cnt_reg;
  reg        fall_flag_reg;
  reg        rise_flag_reg;
  reg        demod_prev_reg;
  reg        car_wait_reg;
  reg        long_en_prev_reg;
  reg        car_en_prev_reg;
  wire       demod_mode = mode_reg[`DTMC_MODE_DEMOD_BIT];
  wire [1:0] f32 = mode_reg[3:2];
  wire [1:0] f54 = mode_reg[5:4];
  wire       wr_mode = wr_in && addr_in == `DTMC_OFF_MODE;
  wire       wr_en = wr_in && addr_in == `DTMC_OFF_ENABLE;
  wire       pingpong = !demod_mode && f32 == `DTMC_OUT_PINGPONG;
  // ----------------------------------------------------------------
  // demodulator input
  // ----------------------------------------------------------------
  wire demod_raw = mode_reg[`DTMC_MODE_ROUTE_BIT] ?
                   alternate_demod_pin_in : primary_demod_pin_in;
  wire demod_lvl;
  dtmc_input_filter u_filter (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (demod_raw),
    .filt_sel_in (demod_mode ? f32 : `DTMC_FILT_NONE),
    .level_out   (demod_lvl)
  );
  wire rise_ev = demod_mode && demod_lvl && !demod_prev_reg;
  wire fall_ev = demod_mode && !demod_lvl && demod_prev_reg;
  wire want_fall = f54 == `DTMC_EDGE_FALL || f54 == `DTMC_EDGE_BOTH;
  wire want_rise = f54 == `DTMC_EDGE_RISE || f54 == `DTMC_EDGE_BOTH;
  wire set_fall = fall_ev && want_fall;
  wire set_rise = rise_ev && want_rise;
  // ----------------------------------------------------------------
  // timer terminal counts
  // ----------------------------------------------------------------
  wire car_run = car_en_reg && !car_wait_reg;
  wire car_zero = car_run && car_cnt_reg == 8'h00;
  wire long_zero = long_en_reg && long_cnt_reg == 16'h0000;
  wire long_start = long_en_reg && !long_en_prev_reg;
  wire car_start = car_en_reg && !car_en_prev_reg;
  wire [15:0] long_reload = {reload_hi_reg, reload_lo_reg};
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= `DTMC_MODE_RESET;
      sync_reg <= 1'b0;
    end else if (stop_recovery_in) begin
      // logic field and sync survive stop recovery
      mode_reg <= {2'b00, f54, 4'h0};
    end else begin
      if (wr_mode) begin
        mode_reg[7:2] <= wdata_in[7:2];
        if (!wdata_in[`DTMC_MODE_DEMOD_BIT]) begin
          mode_reg[1:0] <= wdata_in[1:0];
        end
      end
      if (wr_en) begin
        sync_reg <= wdata_in[`DTMC_EN_SYNC_BIT];
      end
    end
  end
  // edge flags: set wins over a same-cycle clear
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fall_flag_reg  <= 1'b0;
      rise_flag_reg  <= 1'b0;
      demod_prev_reg <= 1'b0;
    end else begin
      demod_prev_reg <= demod_lvl;
      if (set_fall) begin
        fall_flag_reg <= 1'b1;
      end else if (wr_mode && demod_mode && wdata_in[0]) begin
        fall_flag_reg <= 1'b0;
      end
      if (set_rise) begin
        rise_flag_reg <= 1'b1;
      end else if (wr_mode && demod_mode && wdata_in[1]) begin
        rise_flag_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // auxiliary control registers
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      car_reload_reg  <= 8'h00;
      reload_hi_reg   <= 8'h00;
      reload_lo_reg   <= 8'h00;
      car_modulo_reg  <= 1'b0;
      long_modulo_reg <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `DTMC_OFF_CAR_RELOAD: car_reload_reg <= wdata_in;
        `DTMC_OFF_RELOAD_HI:  reload_hi_reg <= wdata_in;
        `DTMC_OFF_RELOAD_LO:  reload_lo_reg <= wdata_in;
        `DTMC_OFF_CAR_CTRL:
          car_modulo_reg <= wdata_in[`DTMC_CTRL_MODULO_BIT];
        `DTMC_OFF_LONG_CTRL:
          long_modulo_reg <= wdata_in[`DTMC_CTRL_MODULO_BIT];
        default: car_reload_reg <= car_reload_reg;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // long timer
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      long_en_reg      <= 1'b0;
      long_en_prev_reg <= 1'b0;
      long_cnt_reg     <= 16'h0000;
      long_tout_reg    <= 1'b0;
      long_timer_output_out <= 1'b0;
    end else begin
      long_en_prev_reg <= long_en_reg;
      if (long_zero) begin
        long_tout_reg <= 1'b1;
      end else if (wr_in && addr_in == `DTMC_OFF_LONG_CTRL &&
                   wdata_in[`DTMC_CTRL_TOUT_BIT]) begin
        long_tout_reg <= 1'b0;
      end
      if (wr_en) begin
        long_en_reg <= wdata_in[`DTMC_EN_LONG_BIT];
      end else if (pingpong && car_zero) begin
        long_en_reg <= 1'b1;
      end else if (long_zero && (pingpong || !long_modulo_reg)) begin
        long_en_reg <= 1'b0;
      end
      if (long_start) begin
        long_cnt_reg <= long_reload;
        long_timer_output_out <= mode_reg[0];
      end else if (long_zero) begin
        long_cnt_reg <= long_reload;
        if (f32 == `DTMC_OUT_NORMAL || pingpong) begin
          long_timer_output_out <= !long_timer_output_out;
        end
      end else if (long_en_reg) begin
        long_cnt_reg <= long_cnt_reg - 16'h0001;
      end
      // forced level overrides start level and toggles
      if (!demod_mode && f32[1]) begin
        long_timer_output_out <= f32[0];
      end
    end
  end
  // ----------------------------------------------------------------
  // carrier timer
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      car_en_reg      <= 1'b0;
      car_en_prev_reg <= 1'b0;
      car_wait_reg    <= 1'b0;
      car_cnt_reg     <= 8'h00;
      car_tout_reg    <= 1'b0;
      carrier_timer_output_out <= 1'b0;
    end else begin
      car_en_prev_reg <= car_en_reg;
      if (car_zero) begin
        car_tout_reg <= 1'b1;
      end else if (wr_in && addr_in == `DTMC_OFF_CAR_CTRL &&
                   wdata_in[`DTMC_CTRL_TOUT_BIT]) begin
        car_tout_reg <= 1'b0;
      end
      if (wr_en) begin
        car_en_reg <= wdata_in[`DTMC_EN_CAR_BIT];
      end else if (pingpong && long_zero) begin
        car_en_reg <= 1'b1;
      end else if (car_zero && (pingpong || !car_modulo_reg)) begin
        car_en_reg <= 1'b0;
      end
      // sync holds the carrier until the long timer starts or wraps
      if (car_start) begin
        car_wait_reg <= sync_reg;
        car_cnt_reg  <= car_reload_reg;
        carrier_timer_output_out <= mode_reg[1];
      end else if (car_wait_reg && (long_start || long_zero)) begin
        car_wait_reg <= 1'b0;
        car_cnt_reg  <= car_reload_reg;
      end else if (car_zero) begin
        car_cnt_reg <= car_reload_reg;
        carrier_timer_output_out <= !carrier_timer_output_out;
      end else if (car_run) begin
        car_cnt_reg <= car_cnt_reg - 8'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // output combination
  // ----------------------------------------------------------------
  reg long_eff;
  reg comb;
  always @* begin
    // force is already applied in the output flop
    long_eff = long_timer_output_out;
    case (f54)
      `DTMC_LOGIC_AND: comb = carrier_timer_output_out & long_eff;
      `DTMC_LOGIC_OR:  comb = carrier_timer_output_out | long_eff;
      `DTMC_LOGIC_NOR: comb = ~(carrier_timer_output_out | long_eff);
      default:         comb = ~(carrier_timer_output_out & long_eff);
    endcase
  end
  assign shared_output_pin_out =
    (!demod_mode && mode_reg[`DTMC_MODE_ROUTE_BIT]) ? comb
                                                    : port_data_in;
  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `DTMC_OFF_MODE: rdata_out <= demod_mode ?
          {mode_reg[7:2], rise_flag_reg, fall_flag_reg} : mode_reg;
        `DTMC_OFF_ENABLE: rdata_out <= {`DTMC_EN_RSVD, sync_reg,
          car_en_reg, long_en_reg};
        `DTMC_OFF_CAR_CTRL:   rdata_out <= {6'h00, car_tout_reg,
                                            car_modulo_reg};
        `DTMC_OFF_CAR_RELOAD: rdata_out <= car_reload_reg;
        `DTMC_OFF_LONG_CTRL:  rdata_out <= {6'h00, long_tout_reg,
                                            long_modulo_reg};
        `DTMC_OFF_RELOAD_HI:  rdata_out <= reload_hi_reg;
        `DTMC_OFF_RELOAD_LO:  rdata_out <= reload_lo_reg;
        `DTMC_OFF_DEMOD_CTRL: rdata_out <= {7'h00, demod_lvl};
        default:              rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // dtmc_timer_ctrl
`default_nettype wire

/* verilog/dtmc_defines.vh */
`ifndef DTMC_DEFINES_VH
`define DTMC_DEFINES_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DTMC_ADDR_W          4
`define DTMC_OFF_MODE        4'h1
`define DTMC_OFF_ENABLE      4'h3
`define DTMC_OFF_CAR_CTRL    4'h4
`define DTMC_OFF_CAR_RELOAD  4'h5
`define DTMC_OFF_LONG_CTRL   4'h6
`define DTMC_OFF_RELOAD_HI   4'h7
`define DTMC_OFF_RELOAD_LO   4'h8
`define DTMC_OFF_DEMOD_CTRL  4'h9
// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define DTMC_MODE_DEMOD_BIT  7
`define DTMC_MODE_ROUTE_BIT  6
`define DTMC_MODE_RESET      8'h00
`define DTMC_OUT_NORMAL      2'b00
`define DTMC_OUT_PINGPONG    2'b01
`define DTMC_OUT_FORCE0      2'b10
`define DTMC_OUT_FORCE1      2'b11
`define DTMC_LOGIC_AND       2'b00
`define DTMC_LOGIC_OR        2'b01
`define DTMC_LOGIC_NOR       2'b10
`define DTMC_LOGIC_NAND      2'b11
`define DTMC_EDGE_FALL       2'b00
`define DTMC_EDGE_RISE       2'b01
`define DTMC_EDGE_BOTH       2'b10
`define DTMC_FILT_NONE       2'b00
`define DTMC_FILT_4          2'b01
`define DTMC_FILT_8          2'b10
`define DTMC_FILT_4_CYC      4'd4
`define DTMC_FILT_8_CYC      4'd8
// ----------------------------------------------------------------
// enable and timer control register fields
// ----------------------------------------------------------------
`define DTMC_EN_SYNC_BIT     2
`define DTMC_EN_CAR_BIT      1
`define DTMC_EN_LONG_BIT     0
`define DTMC_EN_RSVD         5'h1f
`define DTMC_CTRL_MODULO_BIT 0
`define DTMC_CTRL_TOUT_BIT   1
`endif

/* verilog/dtmc_input_filter.v */
`include "dtmc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// pin synchroniser plus selectable glitch filter
// ----------------------------------------------------------------
module dtmc_input_filter (
  input  wire       mclk_in,
  input  wire       rst_n_in,
  input  wire       pin_in,
  input  wire [1:0] filt_sel_in,
  output reg        level_out
);
  reg       s1_reg;
  reg       s2_reg;
  reg       s3_reg;
  reg [3:0] cnt_reg;
  reg [3:0] need;
  always @* begin
    case (filt_sel_in)
      `DTMC_FILT_4: need = `DTMC_FILT_4_CYC;
      `DTMC_FILT_8: need = `DTMC_FILT_8_CYC;
      default:      need = 4'd0;
    endcase
  end
  // level must hold for the chosen count before it is accepted
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      cnt_reg   <= 4'd0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg != s3_reg || s3_reg == level_out) begin
        cnt_reg <= 4'd0;
      end else if (cnt_reg + 4'd1 >= need) begin
        cnt_reg   <= 4'd0;
        level_out <= s3_reg;
      end else begin
        cnt_reg <= cnt_reg + 4'd1;
      end
    end
  end
endmodule // dtmc_input_filter
`default_nettype wire

/* testbench/dtmc_timer_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module dtmc_asserts (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       stop_recovery_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       port_data_in,
  input wire logic       shared_output_pin_out,
  input wire logic       carrier_timer_output_out,
  input wire logic       long_timer_output_out
);
  // ----------------------------------------------------------------
  // shadow of software state
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  logic       sync_reg;
  logic       comb_lvl;
  logic       c_or;
  logic       c_and;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= 8'h00;
      sync_reg <= 1'b0;
    end else if (stop_recovery_in) begin
      mode_reg <= {2'b00, mode_reg[5:4], 4'h0};
    end else if (wr_in && addr_in == 4'h1) begin
      // demod writes hit the flags, not the start levels
      mode_reg <= wdata_in[7] ? {wdata_in[7:2], mode_reg[1:0]} : wdata_in;
    end else if (wr_in && addr_in == 4'h3) begin
      sync_reg <= wdata_in[2];
    end
  end
  assign c_or = carrier_timer_output_out | long_timer_output_out;
  assign c_and = carrier_timer_output_out & long_timer_output_out;
  // bit5 inverts, bit4^bit5 picks or over and
  assign comb_lvl = mode_reg[5] ^ ((mode_reg[4] ^ mode_reg[5]) ? c_or : c_and);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_pin_route;
    shared_output_pin_out ==
      ((!mode_reg[7] && mode_reg[6]) ? comb_lvl : port_data_in);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("shared pin level wrong");
  property p_force_level;
    (!mode_reg[7] && mode_reg[3] && $stable(mode_reg[2])) [*2]
      |-> long_timer_output_out == mode_reg[2];
  endproperty
  a_force_level: assert property (p_force_level)
    else $error("forced long output wrong");
  property p_start_level;
    wr_in && addr_in == 4'h3 && wdata_in[0] && mode_reg[7:2] == 6'h00
      |-> ##3 long_timer_output_out == mode_reg[0];
  endproperty
  a_start_level: assert property (p_start_level)
    else $error("long output start level wrong");
  property p_unmapped;
    rd_in && (addr_in == 4'h0 || addr_in == 4'h2 || addr_in > 4'h9)
      |=> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_enable_rsvd;
    rd_in && addr_in == 4'h3 |=> rdata_out[7:3] == 5'h1f;
  endproperty
  a_enable_rsvd: assert property (p_enable_rsvd)
    else $error("reserved enable bits not ones");
  property p_sync_read;
    rd_in && addr_in == 4'h3 |=> rdata_out[2] == sync_reg;
  endproperty
  a_sync_read: assert property (p_sync_read)
    else $error("sync bit read wrong");
  property p_mode_read;
    rd_in && addr_in == 4'h1 |=> rdata_out[7:2] == mode_reg[7:2] &&
      (mode_reg[7] || rdata_out[1:0] == mode_reg[1:0]);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode register read wrong");
  property p_rdata_hold;
    !rd_in |=> $stable(rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
endmodule // dtmc_asserts

bind dtmc_timer_ctrl dtmc_asserts u_dtmc_asserts (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .stop_recovery_in(stop_recovery_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .port_data_in(port_data_in),
  .shared_output_pin_out(shared_output_pin_out),
  .carrier_timer_output_out(carrier_timer_output_out),
  .long_timer_output_out(long_timer_output_out)
);
`default_nettype wire

/* testbench/test_dual_timer_mode_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_mode_control;
  logic       mclk_in;
  logic       rst_n_in;
  logic       stop_recovery_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       pri_pin;
  logic       alt_pin;
  logic       port_data_in;
  logic       shared_output_pin_out;
  logic       car_out;
  logic       long_out;
  logic [7:0] rv;
  int         err_count;
  int         cmp_count;
  int         k;

  dtmc_timer_ctrl DUT (
    .mclk_in, .rst_n_in, .stop_recovery_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .primary_demod_pin_in(pri_pin),
    .alternate_demod_pin_in(alt_pin), .port_data_in, .shared_output_pin_out,
    .carrier_timer_output_out(car_out), .long_timer_output_out(long_out)
  );

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // an idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
    rv = rdata_out;
  endtask
  task automatic wait_long(input logic v);
    for (k = 0; k < 40 && long_out !== v; k++)
      @(posedge mclk_in);
    chk({7'h0, long_out}, {7'h0, v});
    if (k == 40)
      report_and_stop;
  endtask
  function automatic logic f_comb(input logic [1:0] s, input logic a,
                                  input logic b);
    case (s)
      2'b00:   return a & b;
      2'b01:   return a | b;
      2'b10:   return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(4'h1);
    chk(rv, 8'h00);
    rd(4'h3);
    chk(rv, 8'hf8);
    rd(4'h2);
    chk(rv, 8'h00);
    rd(4'hc);
    chk(rv, 8'h00);
    port_data_in <= 1'b1;
    cyc(1);
    chk({7'h0, shared_output_pin_out}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_enable;
    wr(4'h3, 8'h04);
    rd(4'h3);
    chk(rv, 8'hfc);
    wr(4'h5, 8'h40);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h02);
    rd(4'h3);
    chk(rv, 8'hfa);
    wr(4'h3, 8'h00);
    rd(4'h3);
    chk(rv, 8'hf8);
    $display("test enable done");
  endtask
  task automatic t_long;
    wr(4'h1, 8'h01);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h05);
    wr(4'h6, 8'h01);
    wr(4'h3, 8'h01);
    cyc(2);
    chk({7'h0, long_out}, 8'h01);
    wait_long(1'b0);
    wait_long(1'b1);
    rd(4'h6);
    chk(rv & 8'h02, 8'h02);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h6, 8'h02);
    wr(4'h3, 8'h01);
    cyc(2);
    chk({7'h0, long_out}, 8'h00);
    wait_long(1'b1);
    cyc(20);
    rd(4'h3);
    chk(rv, 8'hf8);
    chk({7'h0, long_out}, 8'h01);
    $display("test long timer done");
  endtask
  task automatic t_carrier;
    wr(4'h1, 8'h02);
    wr(4'h5, 8'h02);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h02);
    cyc(2);
    chk({7'h0, car_out}, 8'h01);
    for (k = 0; k < 40 && car_out !== 1'b0; k++)
      @(posedge mclk_in);
    chk({7'h0, car_out}, 8'h00);
    if (k == 40)
      report_and_stop;
    rd(4'h4);
    chk(rv & 8'h02, 8'h02);
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h06);
    cyc(20);
    chk({7'h0, car_out}, 8'h01);
    wr(4'h3, 8'h07);
    for (k = 0; k < 40 && car_out !== 1'b0; k++)
      @(posedge mclk_in);
    chk({7'h0, car_out}, 8'h00);
    if (k == 40)
      report_and_stop;
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    $display("test carrier done");
  endtask
  task automatic t_out;
    for (int c = 0; c < 4; c++) begin
      for (int f = 2; f < 4; f++) begin
        wr(4'h1, {2'b01, c[1:0], f[1:0], 2'b00});
        cyc(2);
        chk({7'h0, long_out}, {7'h0, f[0]});
        chk({7'h0, shared_output_pin_out},
            {7'h0, f_comb(c[1:0], car_out, long_out)});
      end
    end
    wr(4'h1, 8'h04);
    rd(4'h1);
    chk(rv, 8'h04);
    $display("test output logic done");
  endtask
  task automatic t_stop;
    wr(4'h1, 8'h31);
    wr(4'h3, 8'h04);
    stop_recovery_in <= 1'b1;
    cyc(1);
    stop_recovery_in <= 1'b0;
    cyc(1);
    rd(4'h1);
    chk(rv, 8'h30);
    rd(4'h3);
    chk(rv, 8'hfc);
    rst_n_in <= 1'b0;
    cyc(2);
    rst_n_in <= 1'b1;
    cyc(1);
    rd(4'h1);
    chk(rv, 8'h00);
    rd(4'h3);
    chk(rv, 8'hf8);
    $display("test stop recovery done");
  endtask
  task automatic demod(input logic [7:0] m, input logic alt, input int len,
                       input logic [1:0] e);
    wr(4'h1, m | 8'h03);
    cyc(12);
    wr(4'h1, m | 8'h03);
    rd(4'h1);
    chk(rv, m);
    if (alt)
      alt_pin <= 1'b1;
    else
      pri_pin <= 1'b1;
    cyc(len);
    pri_pin <= 1'b0;
    alt_pin <= 1'b0;
    cyc(16);
    wr(4'h1, m);
    rd(4'h1);
    chk(rv, m | {6'h0, e});
  endtask
  initial begin
    rst_n_in = 1'b0;
    stop_recovery_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    pri_pin = 1'b0;
    alt_pin = 1'b0;
    port_data_in = 1'b0;
    err_count = 0;
    cmp_count = 0;
    cyc(10);
    rst_n_in <= 1'b1;
    cyc(1);
    t_reset;
    t_enable;
    t_long;
    t_carrier;
    t_out;
    t_stop;
    demod(8'h80, 1'b0, 3, 2'b01);
    demod(8'h90, 1'b0, 3, 2'b10);
    demod(8'ha0, 1'b0, 3, 2'b11);
    demod(8'hd0, 1'b0, 3, 2'b00);
    demod(8'hd0, 1'b1, 3, 2'b10);
    demod(8'h94, 1'b0, 2, 2'b00);
    demod(8'h94, 1'b0, 6, 2'b10);
    demod(8'h98, 1'b0, 6, 2'b00);
    demod(8'h98, 1'b0, 12, 2'b10);
    $display("test demodulation done");
    report_and_stop;
  end
endmodule // test_dual_timer_mode_control
`default_nettype wire
